// [cli_params.svh]
// constants for the charge level indicator and key block
// Summary of operation
// - display table chosen by configured lamp count of three, four or five
// - five lamps discharging: one lamp per 20% band, first lamp from 5%
// - four lamps discharging: one lamp per 25% band, first lamp from 5%
// - three lamps discharging: bands at 66% and 33%, first lamp from 5%
// - discharging: first lamp flickers at 1 to 4%, all off at 0%
// - charging: all on at 100%, else current band lamp flickers, lower on
// - low battery: first lamp flickers exactly five times, boost kept off
// - fast charge lamp pin high exactly while input or output fast charging
// - single push key classified as short, long or double short press
// - short press turns on port A, port C light load and display
// - long press toggles the flashlight driver
// - double short press turns off port A, port C and display
// - lamp 4 and lamp 5 pins both tied low select serial mode on the shared pins
// - serial mode answers as two-wire target at 0x3c, 100k and 400k
// - flashlight and decrypt share one pin, only one enabled
`ifndef CLI_PARAMS_SVH
`define CLI_PARAMS_SVH
`define CLI_CLK_HZ          10000000
`define CLI_CYC_PER_MS      (`CLI_CLK_HZ / 1000)
`define CLI_DEBOUNCE_MS     20
`define CLI_LONG_MS         2000
`define CLI_GAP_MS          400
`define CLI_FLICK_HALF_MS   500
`define CLI_LOW_PCT         7'd5
`define CLI_FULL_PCT        7'd100
`define CLI_WARN_TOGGLES    4'd10
`define CLI_I2C_ADDR        7'h3c
`define CLI_I2C_CTRL_REG    8'hb0
`define CLI_CTRL_RST        8'h00
`endif

// [cli_pkg.sv]
// types shared by the charge level indicator block
package cli_pkg;
   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe;
   } cli_lamp_t;

   typedef enum logic [2:0] {
      KEY_IDLE   = 3'b000,
      KEY_PRESS1 = 3'b001,
      KEY_GAP    = 3'b010,
      KEY_PRESS2 = 3'b011,
      KEY_HOLD   = 3'b100
   } cli_key_st_t;

   typedef enum logic [2:0] {
      BUS_IDLE  = 3'b000,
      BUS_ADDR  = 3'b001,
      BUS_REG   = 3'b010,
      BUS_WDATA = 3'b011,
      BUS_RDATA = 3'b100,
      BUS_ACK   = 3'b101,
      BUS_MACK  = 3'b110
   } cli_bus_st_t;
endpackage

// [cli_top.sv]
// battery level lamps, push key decoder, flashlight and shared-pin serial target
`timescale 1ns/1ns
`include "cli_params.svh"
module cli_top #(
   parameter int DEBOUNCE_CYC   = `CLI_DEBOUNCE_MS * `CLI_CYC_PER_MS,
   parameter int LONG_CYC       = `CLI_LONG_MS * `CLI_CYC_PER_MS,
   parameter int GAP_CYC        = `CLI_GAP_MS * `CLI_CYC_PER_MS,
   parameter int FLICK_HALF_CYC = `CLI_FLICK_HALF_MS * `CLI_CYC_PER_MS
) (
   input  wire logic                REF_CLK,
   input  wire logic                RESET_N,
   input  wire logic [6:0]          CAPACITY_PCT,
   input  wire logic                CHARGING,
   input  wire logic                LOW_BATTERY,
   input  wire logic                FAST_CHG_IN,
   input  wire logic                FAST_CHG_OUT,
   input  wire logic                KEY_N,
   input  wire logic                DECRYPT_CFG,
   input  wire logic [4:0]          LAMP_IN,
   output cli_pkg::cli_lamp_t       LAMP,
   output logic                     PORT_A_EN,
   output logic                     PORT_C_EN,
   output logic                     FLASHLIGHT_OR_DECRYPT_PIN,
   output logic                     FAST_CHARGE_LAMP_PIN,
   output logic                     BOOST_BLOCK,
   output logic                     SERIAL_MODE,
   output logic [2:0]               LAMP_COUNT,
   output logic [7:0]               SERIAL_CTRL
);
   import cli_pkg::*;

   // ----------------------------------------
   // reset release and strap detection
   // ----------------------------------------
   logic rst_meta_r, rst_n;
   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N) {rst_n, rst_meta_r} <= 2'b00;
      else          {rst_n, rst_meta_r} <= {rst_meta_r, 1'b1};
   end

   // pins sensed with drivers off, caught once, held until next reset
   logic       det_done_r, serial_r;
   logic [2:0] count_r;
   // three lamps strap pin 4 low and pin 5 high; serial needs both low,
   // otherwise a three lamp board could never leave serial mode
   wire  [2:0] sensed_count = (LAMP_IN[4] & LAMP_IN[3]) ? 3'd5 :
                              (LAMP_IN[3] ? 3'd4 : 3'd3);
   wire        sensed_serial = ~LAMP_IN[3] & ~LAMP_IN[4];
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         det_done_r <= 1'b0;
         serial_r   <= 1'b0;
         count_r    <= 3'd3;
      end
      else if (!det_done_r)
      begin
         det_done_r <= 1'b1;
         serial_r   <= sensed_serial;
         count_r    <= sensed_count;
      end
   end
   assign SERIAL_MODE = serial_r;
   assign LAMP_COUNT  = count_r;

   // ----------------------------------------
   // common flicker clock
   // ----------------------------------------
   logic [31:0] flick_cnt_r;
   logic        phase_r;
   wire         flick_tick = (flick_cnt_r == 32'(FLICK_HALF_CYC - 1));
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)          begin flick_cnt_r <= '0; phase_r <= 1'b0; end
      else if (flick_tick) begin flick_cnt_r <= '0; phase_r <= ~phase_r; end
      else                 flick_cnt_r <= flick_cnt_r + 32'd1;
   end

   // ----------------------------------------
   // key debounce and press classifier
   // ----------------------------------------
   logic [31:0] db_cnt_r, tmr_r;
   logic        key_r, key_prev_r;
   cli_key_st_t key_st_r, key_st_nxt;
   logic        short_p, long_p, double_p;
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)                          begin db_cnt_r <= '0; key_r <= 1'b0; end
      else if (~KEY_N == key_r)            db_cnt_r <= '0;
      else if (db_cnt_r == 32'(DEBOUNCE_CYC - 1))
                                           begin db_cnt_r <= '0; key_r <= ~KEY_N; end
      else                                 db_cnt_r <= db_cnt_r + 32'd1;
   end
   wire key_rise = key_r & ~key_prev_r;
   wire key_fall = ~key_r & key_prev_r;
   wire long_hit = (tmr_r == 32'(LONG_CYC - 1));
   wire gap_out  = (tmr_r == 32'(GAP_CYC - 1));
   always_comb
   begin
      key_st_nxt = key_st_r;
      short_p    = 1'b0;
      long_p     = 1'b0;
      double_p   = 1'b0;
      case (key_st_r)
         KEY_IDLE:   if (key_rise) key_st_nxt = KEY_PRESS1;
         KEY_PRESS1: if (key_fall) key_st_nxt = KEY_GAP;
                     else if (long_hit) begin key_st_nxt = KEY_HOLD; long_p = 1'b1; end
         KEY_GAP:    if (key_rise) key_st_nxt = KEY_PRESS2;
                     else if (gap_out) begin key_st_nxt = KEY_IDLE; short_p = 1'b1; end
         KEY_PRESS2: if (key_fall) begin key_st_nxt = KEY_IDLE; double_p = 1'b1; end
         KEY_HOLD:   if (key_fall) key_st_nxt = KEY_IDLE;
         default:    key_st_nxt = KEY_IDLE;
      endcase
   end
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_st_r <= KEY_IDLE; key_prev_r <= 1'b0; tmr_r <= '0;
      end
      else
      begin
         key_st_r   <= key_st_nxt;
         key_prev_r <= key_r;
         tmr_r      <= (key_st_nxt != key_st_r) ? '0 : tmr_r + 32'd1;
      end
   end

   // ----------------------------------------
   // key actions on ports, display, flashlight
   // ----------------------------------------
   logic ports_on_r, disp_on_r, flash_r;
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n) begin ports_on_r <= 1'b0; disp_on_r <= 1'b0; flash_r <= 1'b0; end
      else
      begin
         if (short_p)  begin ports_on_r <= 1'b1; disp_on_r <= 1'b1; end
         if (double_p) begin ports_on_r <= 1'b0; disp_on_r <= 1'b0; end
         if (long_p)   flash_r <= ~flash_r;
      end
   end
   assign PORT_A_EN   = ports_on_r;
   assign PORT_C_EN   = ports_on_r;
   // decrypt configuration owns the shared pin, flashlight stays dark
   assign FLASHLIGHT_OR_DECRYPT_PIN = flash_r & ~DECRYPT_CFG;
   assign FAST_CHARGE_LAMP_PIN = FAST_CHG_IN | FAST_CHG_OUT;
   assign BOOST_BLOCK = LOW_BATTERY;

   // ----------------------------------------
   // capacity band and lamp pattern
   // ----------------------------------------
   logic [2:0] band;
   always_comb
   begin
      band = 3'd1;
      case (count_r)
         3'd5: band = (CAPACITY_PCT >= 7'd80) ? 3'd5 : (CAPACITY_PCT >= 7'd60) ? 3'd4 :
                      (CAPACITY_PCT >= 7'd40) ? 3'd3 : (CAPACITY_PCT >= 7'd20) ? 3'd2 : 3'd1;
         3'd4: band = (CAPACITY_PCT >= 7'd75) ? 3'd4 : (CAPACITY_PCT >= 7'd50) ? 3'd3 :
                      (CAPACITY_PCT >= 7'd25) ? 3'd2 : 3'd1;
         default: band = (CAPACITY_PCT >= 7'd66) ? 3'd3 :
                         (CAPACITY_PCT >= 7'd33) ? 3'd2 : 3'd1;
      endcase
   end
   logic [4:0] below_mask, band_bit, count_mask;
   always_comb
   begin
      below_mask = '0;
      band_bit   = '0;
      count_mask = '0;
      for (int i = 0; i < 5; i++)
      begin
         below_mask[i] = (3'(i) < band - 3'd1);
         band_bit[i]   = (3'(i) == band - 3'd1);
         count_mask[i] = (3'(i) < count_r);
      end
   end

   // low battery warning: ten half periods give five lit pulses
   logic [3:0] warn_r;
   logic       low_prev_r;
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n) begin warn_r <= '0; low_prev_r <= 1'b0; end
      else
      begin
         low_prev_r <= LOW_BATTERY;
         if (LOW_BATTERY & ~low_prev_r)            warn_r <= `CLI_WARN_TOGGLES;
         else if (flick_tick && warn_r != 4'd0)    warn_r <= warn_r - 4'd1;
      end
   end

   logic [4:0] pattern;
   always_comb
   begin
      if (warn_r != 4'd0)                  pattern = {4'b0, warn_r[0]};
      else if (CHARGING)
         pattern = (CAPACITY_PCT >= `CLI_FULL_PCT) ? 5'h1f :
                   below_mask | (band_bit & {5{phase_r}});
      else if (!disp_on_r)                 pattern = 5'h00;
      else if (CAPACITY_PCT >= `CLI_LOW_PCT) pattern = below_mask | band_bit;
      else if (CAPACITY_PCT != 7'd0)       pattern = {4'b0, phase_r};
      else                                 pattern = 5'h00;
   end

   // ----------------------------------------
   // two-wire target on lamp pins 1 (clock) and 2 (data)
   // ----------------------------------------
   logic        scl_r, sda_r, sda_oe_r, rw_r, addr_ok_r, ack_next_rd_r;
   logic [7:0]  shift_r, reg_ptr_r, ctrl_r;
   logic [3:0]  bit_r;
   logic [1:0]  byte_r;
   cli_bus_st_t bus_r;
   wire scl = LAMP_IN[0];
   wire sda = LAMP_IN[1];
   wire start_c = serial_r & scl_r & scl & sda_r & ~sda;
   wire stop_c  = serial_r & scl_r & scl & ~sda_r & sda;
   wire scl_up  = serial_r & ~scl_r & scl;
   wire scl_dn  = serial_r & scl_r & ~scl;
   wire [7:0] rd_byte = (reg_ptr_r == `CLI_I2C_CTRL_REG) ? ctrl_r :
                        {CHARGING, CAPACITY_PCT};
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_r <= 1'b1; sda_r <= 1'b1; sda_oe_r <= 1'b0; rw_r <= 1'b0;
         addr_ok_r <= 1'b0; ack_next_rd_r <= 1'b0; shift_r <= '0;
         reg_ptr_r <= '0; ctrl_r <= `CLI_CTRL_RST; bit_r <= '0; byte_r <= '0;
         bus_r <= BUS_IDLE;
      end
      else
      begin
         scl_r <= scl;
         sda_r <= sda;
         if (start_c) begin bus_r <= BUS_ADDR; bit_r <= '0; byte_r <= '0; sda_oe_r <= 1'b0; end
         else if (stop_c) begin bus_r <= BUS_IDLE; sda_oe_r <= 1'b0; end
         else if (scl_up)
         begin
            if (bus_r == BUS_MACK) ack_next_rd_r <= ~sda;
            else if (bus_r != BUS_IDLE && bus_r != BUS_ACK && bus_r != BUS_RDATA)
            begin
               shift_r <= {shift_r[6:0], sda};
               bit_r   <= bit_r + 4'd1;
            end
         end
         else if (scl_dn)
         begin
            case (bus_r)
               BUS_ADDR, BUS_REG, BUS_WDATA:
                  if (bit_r == 4'd8)
                  begin
                     bit_r <= '0;
                     if (bus_r == BUS_ADDR)
                     begin
                        addr_ok_r <= (shift_r[7:1] == `CLI_I2C_ADDR);
                        rw_r      <= shift_r[0];
                        sda_oe_r  <= (shift_r[7:1] == `CLI_I2C_ADDR);
                        bus_r     <= (shift_r[7:1] == `CLI_I2C_ADDR) ? BUS_ACK : BUS_IDLE;
                     end
                     else
                     begin
                        if (bus_r == BUS_REG) reg_ptr_r <= shift_r;
                        else if (reg_ptr_r == `CLI_I2C_CTRL_REG) ctrl_r <= shift_r;
                        sda_oe_r <= 1'b1;
                        bus_r    <= BUS_ACK;
                     end
                  end
               BUS_ACK:
               begin
                  byte_r <= (byte_r == 2'd3) ? byte_r : byte_r + 2'd1;
                  if (rw_r) begin bus_r <= BUS_RDATA; sda_oe_r <= ~rd_byte[7];
                             shift_r <= {rd_byte[6:0], 1'b0}; bit_r <= 4'd1; end
                  else begin sda_oe_r <= 1'b0; bus_r <= (byte_r == 2'd0) ? BUS_REG : BUS_WDATA; end
               end
               BUS_RDATA:
                  if (bit_r == 4'd8) begin sda_oe_r <= 1'b0; bus_r <= BUS_MACK; end
                  else begin sda_oe_r <= ~shift_r[7]; shift_r <= {shift_r[6:0], 1'b0};
                             bit_r <= bit_r + 4'd1; end
               BUS_MACK:
                  if (ack_next_rd_r) begin bus_r <= BUS_RDATA; sda_oe_r <= ~rd_byte[7];
                                          shift_r <= {rd_byte[6:0], 1'b0}; bit_r <= 4'd1; end
                  else bus_r <= BUS_IDLE;
               default: ;
            endcase
         end
      end
   end
   assign SERIAL_CTRL = ctrl_r;

   // ----------------------------------------
   // registered pin drive
   // ----------------------------------------
   cli_lamp_t lamp_r;
   wire [4:0] led_oe = det_done_r ? count_mask : 5'h00;
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n) lamp_r <= '0;
      else if (serial_r) lamp_r <= '{out: 5'h00, oe: {3'b0, sda_oe_r, 1'b0}};
      else lamp_r <= '{out: pattern & count_mask, oe: led_oe};
   end
   assign LAMP = lamp_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_FASTLAMP: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      FAST_CHARGE_LAMP_PIN == (FAST_CHG_IN | FAST_CHG_OUT)) else $error("fast lamp mismatch");
   AST_COUNT_HELD: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      det_done_r |=> $stable(count_r) && $stable(serial_r)) else $error("count changed");
   AST_LONG_TOGGLE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      long_p |=> flash_r != $past(flash_r)) else $error("flash not toggled");
   AST_SHORT_ON: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      short_p |=> PORT_A_EN && PORT_C_EN && disp_on_r) else $error("short press no effect");
   AST_DOUBLE_OFF: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      double_p |=> !PORT_A_EN && !PORT_C_EN && !disp_on_r) else $error("double press no effect");
   AST_SHARED_PIN: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      DECRYPT_CFG |-> !FLASHLIGHT_OR_DECRYPT_PIN) else $error("flash on in decrypt config");
   AST_FLICK_DUTY: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      $changed(phase_r) |=> !$changed(phase_r)) else $error("flicker period broken");
   AST_ZERO_OFF: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (!serial_r && det_done_r && warn_r == 4'd0 && !CHARGING && CAPACITY_PCT == 7'd0)
      |=> LAMP.out == 5'h00) else $error("lamps lit at zero");
   AST_FULL_CHG: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (!serial_r && warn_r == 4'd0 && CHARGING && CAPACITY_PCT >= `CLI_FULL_PCT)
      |=> LAMP.out == count_mask) else $error("full charge not all on");
   AST_SERIAL_LAMPS: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      serial_r |=> LAMP.out == 5'h00 && LAMP.oe[0] == 1'b0) else $error("lamps driven in serial");
endmodule

// [cli_far_model.sv]
// far side model: lamp pins with board straps, two-wire host lines, push key
`timescale 1ns/1ns
module cli_far_model
   import cli_pkg::*;
(
   input  cli_pkg::cli_lamp_t lamp,
   input  wire logic [4:0]    strap,
   input  wire logic          scl_host,
   input  wire logic          sda_host,
   input  wire logic          key_down,
   output logic [4:0]         lamp_in,
   output logic               key_n
);
   // ---------------------------------------------------------------
   // pin levels
   // ---------------------------------------------------------------
   logic [4:0] host_rel;

   // host lines are open drain, released high by the bus pull-ups
   assign host_rel = {3'b111, sda_host, scl_host};
   // undriven pin settles to its board strap: a lamp pulls up, a tie holds low
   assign lamp_in = ((lamp.oe & lamp.out) | (~lamp.oe & strap)) & host_rel;
   assign key_n = ~key_down;
endmodule

// [cli_top_tb.sv]
// self-checking bench for the charge level indicator block
`timescale 1ns/1ns
module cli_top_tb;
   import cli_pkg::*;
   localparam int DEB = 4;
   localparam int LNG = 50;
   localparam int GAP = 20;
   localparam int FLK = 8;
   logic       ref_clk = 1'b0, reset_n = 1'b0, charging = 1'b0, low_bat = 1'b0;
   logic       fc_in = 1'b0, fc_out = 1'b0, key_down = 1'b0, decrypt_cfg = 1'b0;
   logic       scl_h = 1'b1, sda_h = 1'b1, key_n;
   logic [6:0] pct = 7'h00;
   logic [4:0] strap = 5'h1f, lamp_in;
   cli_lamp_t  lamp;
   logic       port_a, port_c, flash, fc_lamp, boost_blk, ser_mode;
   logic [2:0] lamp_cnt;
   logic [7:0] ser_ctrl, rd;
   int         err_total = 0;
   int         checked = 0;
   int         pcts [20] = '{100, 80, 79, 76, 75, 66, 65, 60, 50, 49,
                             40, 34, 33, 25, 20, 19, 5, 4, 1, 0};

   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end

   cli_top #(.DEBOUNCE_CYC(DEB), .LONG_CYC(LNG), .GAP_CYC(GAP), .FLICK_HALF_CYC(FLK)) dut (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .CAPACITY_PCT(pct), .CHARGING(charging),
      .LOW_BATTERY(low_bat), .FAST_CHG_IN(fc_in), .FAST_CHG_OUT(fc_out), .KEY_N(key_n),
      .DECRYPT_CFG(decrypt_cfg), .LAMP_IN(lamp_in), .LAMP(lamp), .PORT_A_EN(port_a),
      .PORT_C_EN(port_c), .FLASHLIGHT_OR_DECRYPT_PIN(flash), .FAST_CHARGE_LAMP_PIN(fc_lamp),
      .BOOST_BLOCK(boost_blk), .SERIAL_MODE(ser_mode), .LAMP_COUNT(lamp_cnt),
      .SERIAL_CTRL(ser_ctrl));

   cli_far_model partner (.lamp(lamp), .strap(strap), .scl_host(scl_h), .sda_host(sda_h),
      .key_down(key_down), .lamp_in(lamp_in), .key_n(key_n));

   // ---------------------------------------------------------------
   // basic tasks
   // ---------------------------------------------------------------
   // every drive lands a fixed 10 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic do_reset(input logic [4:0] s);
      reset_n = 1'b0;
      strap = s;
      cyc(20);
      reset_n = 1'b1;
      cyc(6);
   endtask

   // release wait covers debounce so the next press starts clean
   task automatic press(input int n);
      key_down = 1'b1;
      cyc(n);
      key_down = 1'b0;
      cyc(DEB + 2);
   endtask

   // ---------------------------------------------------------------
   // display expectation and sampling
   // ---------------------------------------------------------------
   function automatic logic [9:0] expect_disp(input int p, input int n, input logic chg);
      int b;
      logic [4:0] on, fl;
      b = 0;
      for (int k = 1; k < n; k++)
         if (p >= k * (100 / n))
            b++;
      on = 5'h00;
      fl = 5'h00;
      if (chg && p >= 100)
         on = 5'((1 << n) - 1);
      else if (chg)
      begin
         on = 5'((1 << b) - 1);
         fl = 5'(1 << b);
      end
      else if (p >= 5)
         on = 5'((1 << (b + 1)) - 1);
      else if (p >= 1)
         fl = 5'h01;
      return {on, fl};
   endfunction

   // steady catches lamps never dark, seen catches lamps lit at some point
   task automatic check_disp(input int p, input logic chg, input int n);
      logic [4:0] steady, seen, high_oe;
      logic [9:0] e;
      pct = 7'(p);
      charging = chg;
      cyc(3);
      steady = 5'h1f;
      seen = 5'h00;
      high_oe = 5'h00;
      repeat (2 * FLK + 4)
      begin
         steady &= lamp.out;
         seen |= lamp.out;
         high_oe |= lamp.oe & ~5'((1 << n) - 1);
         cyc(1);
      end
      e = expect_disp(p, n, chg);
      chk("lamps steady", 8'(e[9:5]), 8'(steady));
      chk("lamps lit", 8'(e[9:5] | e[4:0]), 8'(seen));
      chk("lamps beyond count", 8'h00, 8'(high_oe));
   endtask

   task automatic i2c_bit(input logic b, output logic seen);
      sda_h = b;
      cyc(4);
      scl_h = 1'b1;
      cyc(2);
      seen = lamp_in[1];
      cyc(2);
      scl_h = 1'b0;
      cyc(4);
   endtask

   task automatic i2c_byte(input logic [7:0] b, input logic ack_exp, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--)
         i2c_bit(b[i], r[i]);
      i2c_bit(1'b1, a);
      chk("serial acknowledge", 8'(ack_exp), 8'(a));
   endtask

   // stop low gives a start and leaves the clock low for the first bit,
   // stop high gives a stop and leaves the bus idle with the clock high
   task automatic i2c_edge(input logic stop);
      sda_h = ~stop;
      scl_h = 1'b1;
      cyc(4);
      sda_h = stop;
      cyc(4);
      scl_h = stop;
      cyc(4);
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      err_total++;
      end_sim();
   end

   initial
   begin
      int rises;
      logic prev;
      do_reset(5'h1f);
      chk("lamp count", 8'h05, 8'(lamp_cnt));
      chk("serial mode", 8'h00, 8'(ser_mode));
      pct = 7'd50;
      cyc(3);
      chk("blank display", 8'h00, 8'(lamp.out));
      key_down = 1'b1;
      cyc(2);
      key_down = 1'b0;
      cyc(GAP + 10);
      chk("port a after glitch", 8'h00, 8'(port_a));
      press(10);
      cyc(GAP + 10);
      chk("port a", 8'h01, 8'(port_a));
      chk("port c", 8'h01, 8'(port_c));
      foreach (pcts[i]) check_disp(pcts[i], 1'b0, 5);
      foreach (pcts[i]) check_disp(pcts[i], 1'b1, 5);
      $display("test five lamp tables done");
      press(LNG + 20);
      chk("flashlight on", 8'h01, 8'(flash));
      decrypt_cfg = 1'b1;
      cyc(1);
      chk("flashlight gated", 8'h00, 8'(flash));
      decrypt_cfg = 1'b0;
      press(LNG + 20);
      chk("flashlight off", 8'h00, 8'(flash));
      pct = 7'd0;
      charging = 1'b0;
      cyc(3);
      rises = 0;
      prev = 1'b0;
      low_bat = 1'b1;
      repeat (14 * FLK)
      begin
         cyc(1);
         if (lamp.out[0] === 1'b1 && prev !== 1'b1)
            rises++;
         prev = lamp.out[0];
      end
      chk("warning pulses", 8'h05, 8'(rises));
      chk("boost block", 8'h01, 8'(boost_blk));
      low_bat = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         {fc_in, fc_out} = 2'(i);
         cyc(1);
         chk("fast charge lamp", 8'(i != 0), 8'(fc_lamp));
      end
      chk("boost released", 8'h00, 8'(boost_blk));
      press(10);
      press(10);
      cyc(GAP + 10);
      chk("port a off", 8'h00, 8'(port_a));
      chk("port c off", 8'h00, 8'(port_c));
      pct = 7'd50;
      cyc(3);
      chk("display off", 8'h00, 8'(lamp.out));
      chk("lamp count held", 8'h05, 8'(lamp_cnt));
      $display("test five lamp keys done");
      for (int n = 4; n >= 3; n--)
      begin
         do_reset(n == 4 ? 5'h0f : 5'h17);
         chk("lamp count", 8'(n), 8'(lamp_cnt));
         chk("serial mode", 8'h00, 8'(ser_mode));
         press(10);
         cyc(GAP + 10);
         foreach (pcts[i]) check_disp(pcts[i], 1'b0, n);
         foreach (pcts[i]) check_disp(pcts[i], 1'b1, n);
         $display("test %0d lamp tables done", n);
      end
      do_reset(5'h07);
      chk("lamp count", 8'h03, 8'(lamp_cnt));
      chk("serial mode", 8'h01, 8'(ser_mode));
      i2c_edge(1'b0);
      i2c_byte(8'h78, 1'b0, rd);
      i2c_byte(8'hb0, 1'b0, rd);
      i2c_byte(8'h5a, 1'b0, rd);
      i2c_edge(1'b1);
      chk("serial control", 8'h5a, ser_ctrl);
      i2c_edge(1'b0);
      i2c_byte(8'h79, 1'b0, rd);
      i2c_byte(8'hff, 1'b1, rd);
      i2c_edge(1'b1);
      chk("serial read", 8'h5a, rd);
      i2c_edge(1'b0);
      i2c_byte(8'h7a, 1'b1, rd);
      i2c_edge(1'b1);
      chk("lamp outputs", 8'h00, 8'(lamp.out));
      $display("test serial mode done");
      end_sim();
   end
endmodule
